// ---- hw/irq_sleep_pkg.sv ----
// Constants, carrier structs and state types for the interrupt priority and sleep control block.
package irq_sleep_pkg;

    localparam int NUM_IRQ = 256;
    localparam int PRIO_KEPT = 2;
    localparam int PRIO_KEEP_LSB = 6;
    localparam int PREEMPT_BIT = 7;

    localparam logic [11:0] OFS_ACTIVE_HI = 12'h304;
    localparam logic [11:0] OFS_PRIO_FIRST = 12'h400;
    localparam logic [11:0] OFS_PRIO_LAST = 12'h4FF;
    localparam logic [11:0] OFS_SLEEP_CTRL = 12'hD10;
    localparam logic [11:0] CSR_NEST_STACK = 12'h804;

    localparam int SC_SOFT_RESET = 31;
    localparam int SC_EVENT_SET = 5;
    localparam int SC_WAKE_ON_PEND = 4;
    localparam int SC_WFI_AS_WFE = 3;
    localparam int SC_DEEP_SLEEP = 2;
    localparam int SC_SLEEP_ON_EXIT = 1;
    localparam int CSR_NESTING_BIT = 1;
    localparam int CSR_HW_SAVE_BIT = 0;

    localparam logic RST_CTRL_BIT = 1'b0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_WAIT_EVENT = 3'b010,
        ST_WAIT_IRQ = 3'b100
    } sleep_state_e;

    typedef struct packed {
        logic ext_event_en;
        logic pend_enabled;
        logic pend_any;
    } wake_src_s;

    typedef struct packed {
        logic wait_event_instr;
        logic wait_irq_instr;
        logic handler_return;
    } core_cmd_s;

    typedef struct packed {
        logic flag;
    } ev_mem_s;

    typedef struct packed {
        logic [NUM_IRQ-1:0][PRIO_KEPT-1:0] prio;
        logic nesting_enable;
        logic hw_context_save_enable;
        logic wake_on_pending;
        logic wait_irq_as_wait_event;
        logic deep_sleep_select;
        logic sleep_on_handler_return;
        logic soft_system_reset;
        logic [31:0] mm_rdata;
        logic mm_rvalid;
        logic [31:0] csr_rdata;
        logic csr_ack;
        logic csr_illegal;
        sleep_state_e st;
        logic wait_done;
        logic [7:0] query_prio;
        logic query_preempt;
    } ctrl_state_s;

endpackage : irq_sleep_pkg

// ---- hw/event_memory.sv ----
// Sticky event memory that lets a later wait-for-event complete at once.
`timescale 1ns/1ps
module event_memory (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ev_set,
    input wire logic ev_consume,
    output logic ev_pending
);
    irq_sleep_pkg::ev_mem_s state_r;
    irq_sleep_pkg::ev_mem_s state_nxt;

    // A new event in the consuming cycle survives, so no event is lost.
    always_comb begin
        state_nxt.flag = ev_set | (state_r.flag & ~ev_consume);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r.flag <= irq_sleep_pkg::RST_CTRL_BIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ev_pending = state_r.flag;
endmodule : event_memory

// ---- hw/interrupt_priority_sleep_ctrl.sv ----
// Interrupt priority store, active status, sleep/wake control and nesting CSR.
`timescale 1ns/1ps
module interrupt_priority_sleep_ctrl (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mm_sel,
    input wire logic mm_we,
    input wire logic [11:0] mm_addr,
    input wire logic [3:0] mm_be,
    input wire logic [31:0] mm_wdata,
    output logic [31:0] mm_rdata,
    output logic mm_rvalid,
    input wire logic csr_valid,
    input wire logic csr_we,
    input wire logic [11:0] csr_addr,
    input wire logic csr_priv_machine,
    input wire logic [31:0] csr_wdata,
    output logic [31:0] csr_rdata,
    output logic csr_ack,
    output logic csr_illegal,
    input wire logic [6:0] irq_active_flag,
    input wire irq_sleep_pkg::wake_src_s wake_src,
    input wire irq_sleep_pkg::core_cmd_s core_cmd,
    input wire logic [7:0] irq_query_num,
    output logic [7:0] irq_query_prio,
    output logic irq_query_preempt,
    output logic nesting_enable,
    output logic hw_context_save_enable,
    output logic soft_system_reset,
    output logic core_sleeping,
    output logic core_deep_sleep,
    output logic wait_done
);
    irq_sleep_pkg::ctrl_state_s state_r;
    irq_sleep_pkg::ctrl_state_s state_nxt;

    logic ev_pending;
    logic ev_set;
    logic ev_consume;

    // Only the two kept bits are stored; the rest are rebuilt as zero.
    function automatic logic [7:0] prio_byte(
        input logic [irq_sleep_pkg::PRIO_KEPT-1:0] kept
    );
        prio_byte = {kept, 6'h00};
    endfunction : prio_byte

    function automatic logic prio_hit(input logic [11:0] a);
        prio_hit = (a >= irq_sleep_pkg::OFS_PRIO_FIRST) && (a <= irq_sleep_pkg::OFS_PRIO_LAST);
    endfunction : prio_hit

    event_memory u_event_memory (
        .clk_sys(clk_sys),
        .reset(reset),
        .ev_set(ev_set),
        .ev_consume(ev_consume),
        .ev_pending(ev_pending)
    );

    always_comb begin
        logic [5:0] widx;
        logic [7:0] idx;
        logic ev_now;
        logic wfe_cmd;
        logic csr_mine;
        logic [31:0] rd;
        widx = mm_addr[7:2];
        idx = 8'h00;
        ev_now = 1'b0;
        wfe_cmd = 1'b0;
        csr_mine = 1'b0;
        rd = irq_sleep_pkg::RST_WORD;
        ev_consume = 1'b0;
        state_nxt = state_r;
        state_nxt.mm_rvalid = 1'b0;
        state_nxt.csr_ack = 1'b0;
        state_nxt.csr_illegal = 1'b0;
        state_nxt.soft_system_reset = 1'b0;
        state_nxt.wait_done = 1'b0;

        // Memory-mapped register writes.
        if (mm_sel && mm_we) begin
            if (prio_hit(mm_addr)) begin
                for (int l = 0; l < 4; l++) begin
                    idx = {widx, 2'(l)};
                    if (mm_be[l]) begin
                        state_nxt.prio[idx] = mm_wdata[8*l+7 -: 2];
                    end
                end
            end else if (mm_addr == irq_sleep_pkg::OFS_SLEEP_CTRL) begin
                if (mm_be[3] && mm_wdata[irq_sleep_pkg::SC_SOFT_RESET]) begin
                    state_nxt.soft_system_reset = 1'b1;
                end
                if (mm_be[0]) begin
                    state_nxt.wake_on_pending = mm_wdata[irq_sleep_pkg::SC_WAKE_ON_PEND];
                    state_nxt.wait_irq_as_wait_event = mm_wdata[irq_sleep_pkg::SC_WFI_AS_WFE];
                    state_nxt.deep_sleep_select = mm_wdata[irq_sleep_pkg::SC_DEEP_SLEEP];
                    state_nxt.sleep_on_handler_return =
                        mm_wdata[irq_sleep_pkg::SC_SLEEP_ON_EXIT];
                end
            end
        end

        // Memory-mapped reads answer one cycle later; unmapped reads give zero.
        if (mm_sel && !mm_we) begin
            state_nxt.mm_rvalid = 1'b1;
            if (prio_hit(mm_addr)) begin
                for (int l = 0; l < 4; l++) begin
                    idx = {widx, 2'(l)};
                    rd[8*l +: 8] = prio_byte(state_r.prio[idx]);
                end
            end else if (mm_addr == irq_sleep_pkg::OFS_ACTIVE_HI) begin
                rd[6:0] = irq_active_flag;
            end else if (mm_addr == irq_sleep_pkg::OFS_SLEEP_CTRL) begin
                // Reset and event-set bits are write-only and read zero.
                rd[irq_sleep_pkg::SC_WAKE_ON_PEND] = state_r.wake_on_pending;
                rd[irq_sleep_pkg::SC_WFI_AS_WFE] = state_r.wait_irq_as_wait_event;
                rd[irq_sleep_pkg::SC_DEEP_SLEEP] = state_r.deep_sleep_select;
                rd[irq_sleep_pkg::SC_SLEEP_ON_EXIT] = state_r.sleep_on_handler_return;
            end
            state_nxt.mm_rdata = rd;
        end

        // The CSR port is a separate 12-bit space, answered only for our address.
        csr_mine = csr_valid && (csr_addr == irq_sleep_pkg::CSR_NEST_STACK);
        if (csr_mine) begin
            if (!csr_priv_machine) begin
                state_nxt.csr_illegal = 1'b1;
                state_nxt.csr_rdata = irq_sleep_pkg::RST_WORD;
            end else begin
                state_nxt.csr_ack = 1'b1;
                state_nxt.csr_rdata = irq_sleep_pkg::RST_WORD;
                state_nxt.csr_rdata[irq_sleep_pkg::CSR_NESTING_BIT] = state_r.nesting_enable;
                state_nxt.csr_rdata[irq_sleep_pkg::CSR_HW_SAVE_BIT] =
                    state_r.hw_context_save_enable;
                if (csr_we) begin
                    state_nxt.nesting_enable = csr_wdata[irq_sleep_pkg::CSR_NESTING_BIT];
                    state_nxt.hw_context_save_enable =
                        csr_wdata[irq_sleep_pkg::CSR_HW_SAVE_BIT];
                end
            end
        end

        // Priority lookup for the arbiter; preemption exists only with nesting on.
        state_nxt.query_prio = prio_byte(state_r.prio[irq_query_num]);
        state_nxt.query_preempt = state_r.nesting_enable &&
            state_r.prio[irq_query_num][
                irq_sleep_pkg::PREEMPT_BIT - irq_sleep_pkg::PRIO_KEEP_LSB];

        // Wake sources for wait-for-event.
        ev_now = wake_src.ext_event_en | wake_src.pend_enabled;
        if (mm_sel && mm_we && mm_be[0] && (mm_addr == irq_sleep_pkg::OFS_SLEEP_CTRL) &&
            mm_wdata[irq_sleep_pkg::SC_EVENT_SET]) begin
            ev_now = 1'b1;
        end
        if (state_r.wake_on_pending && wake_src.pend_any) begin
            ev_now = 1'b1;
        end

        wfe_cmd = core_cmd.wait_event_instr ||
            (core_cmd.wait_irq_instr && state_r.wait_irq_as_wait_event);

        case (state_r.st)
            irq_sleep_pkg::ST_RUN: begin
                if (wfe_cmd) begin
                    if (ev_now || ev_pending) begin
                        state_nxt.wait_done = 1'b1;
                        ev_consume = 1'b1;
                    end else begin
                        state_nxt.st = irq_sleep_pkg::ST_WAIT_EVENT;
                    end
                end else if (core_cmd.wait_irq_instr) begin
                    state_nxt.st = irq_sleep_pkg::ST_WAIT_IRQ;
                end else if (core_cmd.handler_return && state_r.sleep_on_handler_return) begin
                    state_nxt.st = irq_sleep_pkg::ST_WAIT_IRQ;
                end
            end
            irq_sleep_pkg::ST_WAIT_EVENT: begin
                if (ev_now || ev_pending) begin
                    state_nxt.st = irq_sleep_pkg::ST_RUN;
                    state_nxt.wait_done = 1'b1;
                    ev_consume = 1'b1;
                end
            end
            irq_sleep_pkg::ST_WAIT_IRQ: begin
                if (wake_src.pend_enabled) begin
                    state_nxt.st = irq_sleep_pkg::ST_RUN;
                    state_nxt.wait_done = 1'b1;
                end
            end
            default: begin
                state_nxt.st = irq_sleep_pkg::ST_RUN;
            end
        endcase

        // An event that completes a wait-for-event is spent; any other is remembered.
        ev_set = ev_now && !ev_consume;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r.prio <= '0;
            state_r.nesting_enable <= irq_sleep_pkg::RST_CTRL_BIT;
            state_r.hw_context_save_enable <= irq_sleep_pkg::RST_CTRL_BIT;
            state_r.wake_on_pending <= irq_sleep_pkg::RST_CTRL_BIT;
            state_r.wait_irq_as_wait_event <= irq_sleep_pkg::RST_CTRL_BIT;
            state_r.deep_sleep_select <= irq_sleep_pkg::RST_CTRL_BIT;
            state_r.sleep_on_handler_return <= irq_sleep_pkg::RST_CTRL_BIT;
            state_r.soft_system_reset <= irq_sleep_pkg::RST_CTRL_BIT;
            state_r.mm_rdata <= irq_sleep_pkg::RST_WORD;
            state_r.mm_rvalid <= 1'b0;
            state_r.csr_rdata <= irq_sleep_pkg::RST_WORD;
            state_r.csr_ack <= 1'b0;
            state_r.csr_illegal <= 1'b0;
            state_r.st <= irq_sleep_pkg::ST_RUN;
            state_r.wait_done <= 1'b0;
            state_r.query_prio <= 8'h00;
            state_r.query_preempt <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign mm_rdata = state_r.mm_rdata;
    assign mm_rvalid = state_r.mm_rvalid;
    assign csr_rdata = state_r.csr_rdata;
    assign csr_ack = state_r.csr_ack;
    assign csr_illegal = state_r.csr_illegal;
    assign irq_query_prio = state_r.query_prio;
    assign irq_query_preempt = state_r.query_preempt;
    assign nesting_enable = state_r.nesting_enable;
    assign hw_context_save_enable = state_r.hw_context_save_enable;
    assign soft_system_reset = state_r.soft_system_reset;
    assign core_sleeping = (state_r.st != irq_sleep_pkg::ST_RUN);
    // Deep sleep is only a selection; it shows while the core actually sleeps.
    assign core_deep_sleep = core_sleeping && state_r.deep_sleep_select;
    assign wait_done = state_r.wait_done;
endmodule : interrupt_priority_sleep_ctrl

// ---- sim/irq_sleep_sva.sv ----
// Concurrent checks on the ports of the interrupt priority and sleep control block.
`timescale 1ns/1ps
module irq_sleep_sva (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mm_sel,
    input wire logic mm_we,
    input wire logic [11:0] mm_addr,
    input wire logic [3:0] mm_be,
    input wire logic [31:0] mm_wdata,
    input wire logic [31:0] mm_rdata,
    input wire logic mm_rvalid,
    input wire logic csr_valid,
    input wire logic csr_we,
    input wire logic [11:0] csr_addr,
    input wire logic csr_priv_machine,
    input wire logic [31:0] csr_wdata,
    input wire logic [31:0] csr_rdata,
    input wire logic csr_ack,
    input wire logic csr_illegal,
    input wire logic [6:0] irq_active_flag,
    input wire logic [7:0] irq_query_prio,
    input wire logic irq_query_preempt,
    input wire logic nesting_enable,
    input wire logic hw_context_save_enable,
    input wire logic soft_system_reset,
    input wire logic core_sleeping,
    input wire logic core_deep_sleep,
    input wire logic wait_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence prio_rd; mm_sel && !mm_we && mm_addr[11:8] == 4'h4; endsequence
    sequence csr_hit; csr_valid && csr_addr == 12'h804; endsequence
    AST_RVALID: assert property (mm_rvalid == $past(mm_sel && !mm_we))
        else $error("rvalid");
    AST_PRIO_LOW: assert property (prio_rd |=> (mm_rdata & 32'h3F3F3F3F) == 32'h0)
        else $error("priority low bits set");
    AST_ACTIVE: assert property (mm_sel && !mm_we && mm_addr == 12'h304
        |=> mm_rdata == {25'h0, $past(irq_active_flag)}) else $error("active status");
    AST_SCTRL_RSV: assert property (mm_sel && !mm_we && mm_addr == 12'hD10
        |=> mm_rdata[31:5] == 27'h0 && !mm_rdata[0]) else $error("control reserved bits");
    AST_SOFT_RESET: assert property (soft_system_reset == $past(mm_sel && mm_we
        && mm_addr == 12'hD10 && mm_be[3] && mm_wdata[31])) else $error("soft reset pulse");
    AST_CSR_ACK: assert property (csr_hit ##0 csr_priv_machine
        |=> csr_ack && !csr_illegal) else $error("csr ack");
    AST_CSR_ILLEGAL: assert property (csr_hit ##0 !csr_priv_machine
        |=> csr_illegal && !csr_ack && csr_rdata == 32'h0) else $error("csr illegal");
    AST_CSR_IGNORE: assert property (csr_valid && csr_addr != 12'h804
        |=> !csr_ack && !csr_illegal) else $error("csr other address");
    AST_CSR_WRITE: assert property (csr_hit ##0 csr_we && csr_priv_machine
        |=> {nesting_enable, hw_context_save_enable} == $past(csr_wdata[1:0]))
        else $error("csr write");
    AST_CSR_HOLD: assert property (!(csr_valid && csr_we && csr_priv_machine)
        |=> $stable({nesting_enable, hw_context_save_enable})) else $error("csr hold");
    AST_PREEMPT: assert property (irq_query_preempt == (irq_query_prio[7]
        && $past(nesting_enable))) else $error("preempt");
    AST_DEEP: assert property (core_deep_sleep |-> core_sleeping) else $error("deep");
    AST_WAKE_DONE: assert property ($fell(core_sleeping) |-> wait_done) else $error("wake");
endmodule : irq_sleep_sva

bind interrupt_priority_sleep_ctrl irq_sleep_sva i_irq_sleep_sva (.*);

// ---- sim/core_model.sv ----
// Behavioural core and interrupt sources driving command, wake and status inputs.
`timescale 1ns/1ps
module core_model (
    input wire logic clk_sys,
    output logic [6:0] irq_active_flag,
    output irq_sleep_pkg::wake_src_s wake_src,
    output irq_sleep_pkg::core_cmd_s core_cmd
);
    initial begin
        irq_active_flag = 7'h00;
        wake_src = '0;
        core_cmd = '0;
    end
    // Each call is one pulse of exactly one clock, so two commands never overlap.
    task automatic pulse(input logic [2:0] c, input logic [2:0] w);
        @(negedge clk_sys);
        core_cmd = c;
        wake_src = w;
        @(negedge clk_sys);
        core_cmd = '0;
        wake_src = '0;
    endtask : pulse
    task automatic set_active(input logic [6:0] a);
        @(negedge clk_sys);
        irq_active_flag = a;
    endtask : set_active
endmodule : core_model

// ---- sim/tb.sv ----
// Self-checking bench for the interrupt priority and sleep control block.
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0, reset = 1'b1, mm_sel = 1'b0, mm_we = 1'b0, mm_rvalid;
    logic csr_valid = 1'b0, csr_we = 1'b0, csr_priv_machine = 1'b1, csr_ack, csr_illegal;
    logic [11:0] mm_addr = 12'h000, csr_addr = 12'h000;
    logic [3:0] mm_be = 4'h0, be;
    logic [31:0] mm_wdata = 32'h0, csr_wdata = 32'h0, mm_rdata, csr_rdata, d;
    logic [6:0] irq_active_flag;
    irq_sleep_pkg::wake_src_s wake_src;
    irq_sleep_pkg::core_cmd_s core_cmd;
    logic [7:0] irq_query_num = 8'h00, irq_query_prio;
    logic irq_query_preempt, nesting_enable, hw_context_save_enable, soft_system_reset;
    logic core_sleeping, core_deep_sleep, wait_done;
    logic [7:0] pb [0:255];
    logic [31:0] exp_q [$];
    int err_count = 0, num_checks = 0, cycles = 0, j, l, n, k;

    always #5 clk_sys = ~clk_sys;
    interrupt_priority_sleep_ctrl i_interrupt_priority_sleep_ctrl (.*);
    core_model i_core_model (.clk_sys(clk_sys), .irq_active_flag(irq_active_flag),
        .wake_src(wake_src), .core_cmd(core_cmd));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Called at a falling edge; the request stays up until the caller lowers it.
    task automatic mm(input logic we, input logic [11:0] a, input logic [3:0] b,
                      input logic [31:0] wd, input logic [31:0] exp);
        {csr_valid, mm_sel, mm_we, mm_addr, mm_be, mm_wdata} = {2'b01, we, a, b, wd};
        if (!we) exp_q.push_back(exp);
        @(negedge clk_sys);
    endtask : mm
    task automatic csr(input logic we, input logic pv, input logic [11:0] a,
                       input logic [31:0] wd, input logic [31:0] exp);
        {mm_sel, csr_valid, csr_we, csr_priv_machine, csr_addr, csr_wdata} = {2'b01, we, pv, a, wd};
        if (pv && a == 12'h804) exp_q.push_back(exp);
        @(negedge clk_sys);
    endtask : csr
    task automatic idle;
        {mm_sel, csr_valid} = 2'b00;
    endtask : idle
    task automatic sp(input logic [2:0] c, input logic [2:0] w, input logic [2:0] e);
        i_core_model.pulse(c, w);
        check({29'h0, core_sleeping, core_deep_sleep, wait_done}, {29'h0, e});
    endtask : sp

    // Outputs are looked at half a cycle after the edge that launches them.
    always @(negedge clk_sys) begin
        if (mm_rvalid === 1'b1) check(mm_rdata, exp_q.pop_front());
        if (csr_ack === 1'b1) check(csr_rdata, exp_q.pop_front());
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        d = $urandom(54);
        for (k = 0; k < 256; k++) pb[k] = 8'h00;
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        mm(1'b0, 12'h304, 4'h0, 32'h0, 32'h0);
        mm(1'b0, 12'h400, 4'h0, 32'h0, 32'h0);
        mm(1'b0, 12'hD10, 4'h0, 32'h0, 32'h0);
        csr(1'b0, 1'b1, 12'h804, 32'h0, 32'h0);
        for (k = 0; k < 12; k++) begin
            j = (k == 0) ? 63 : $urandom_range(63);
            be = 4'($urandom_range(15));
            d = $urandom;
            for (l = 0; l < 4; l++) if (be[l]) pb[4*j+l] = d[8*l+:8] & 8'hC0;
            mm(1'b1, 12'h400 + 12'(4 * j), be, d, 32'h0);
            mm(1'b0, 12'h400 + 12'(4 * j), 4'h0, 32'h0,
               {pb[4*j+3], pb[4*j+2], pb[4*j+1], pb[4*j]});
        end
        mm(1'b1, 12'h500, 4'hF, 32'hFFFFFFFF, 32'h0);
        mm(1'b0, 12'h500, 4'h0, 32'h0, 32'h0);
        for (n = 0; n < 2; n++) begin
            csr(1'b1, 1'b1, 12'h804, 32'(2 * n), 32'h0);
            idle();
            for (l = 0; l < 4; l++) begin
                irq_query_num = 8'(4 * j + l);
                @(negedge clk_sys);
                check({24'h0, irq_query_prio}, {24'h0, pb[4*j+l]});
                check({31'h0, irq_query_preempt}, {31'h0, pb[4*j+l][7] & n[0]});
            end
        end
        csr(1'b1, 1'b1, 12'h804, 32'hFFFFFFFF, 32'h2);
        check({30'h0, nesting_enable, hw_context_save_enable}, 32'h3);
        csr(1'b1, 1'b0, 12'h804, 32'h0, 32'h0);
        csr(1'b1, 1'b1, 12'h805, 32'h0, 32'h0);
        csr(1'b0, 1'b1, 12'h804, 32'h0, 32'h3);
        for (k = 0; k < 3; k++) begin
            idle();
            d = $urandom;
            i_core_model.set_active(d[6:0]);
            mm(1'b1, 12'h304, 4'hF, 32'hFFFFFFFF, 32'h0);
            mm(1'b0, 12'h304, 4'h0, 32'h0, {25'h0, d[6:0]});
        end
        mm(1'b1, 12'hD10, 4'hF, 32'hFFFFFFFF, 32'h0);
        check({31'h0, soft_system_reset}, 32'h1);
        mm(1'b0, 12'hD10, 4'h0, 32'h0, 32'h0000001E);
        idle();
        sp(3'b100, 3'b000, 3'b001);
        sp(3'b010, 3'b000, 3'b110);
        sp(3'b000, 3'b001, 3'b001);
        mm(1'b1, 12'hD10, 4'h1, 32'h00000002, 32'h0);
        idle();
        sp(3'b100, 3'b000, 3'b100);
        sp(3'b000, 3'b001, 3'b100);
        sp(3'b000, 3'b100, 3'b001);
        sp(3'b001, 3'b000, 3'b100);
        sp(3'b000, 3'b010, 3'b001);
        mm(1'b1, 12'hD10, 4'h1, 32'h0, 32'h0);
        idle();
        sp(3'b001, 3'b000, 3'b000);
        sp(3'b010, 3'b000, 3'b100);
        sp(3'b000, 3'b100, 3'b100);
        sp(3'b000, 3'b010, 3'b001);
        repeat (3) @(negedge clk_sys);
        final_report();
    end
endmodule : tb
